// [hw/breaker_ctrl_defs.svh]
// Constants of the breaker control command handler: addresses, codes, field positions, timing.
// Assumes a 16-bit Modbus protocol data unit address space as seen after frame decoding.
`ifndef BREAKER_CTRL_DEFS_SVH
`define BREAKER_CTRL_DEFS_SVH

// Function codes
`define FC_READ_REGS 8'h03
`define FC_WRITE_COIL 8'h05
`define FC_WRITE_REG 8'h06
`define FC_WRITE_COILS 8'h0f
`define FC_WRITE_REGS 8'h10
`define FC_RW_REGS 8'h17

// Exception codes
`define EXC_NONE 8'h00
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03

// Coil block, offsets relative to the coil base
`define COIL_BASE 16'h2000
`define COIL_COUNT 5'h10
`define COIL_WEAR_ACK 4'h1
`define COIL_TRIP_SEL 4'h2
`define COIL_CLOSE_SEL 4'h3
`define COIL_CANCEL 4'h4
`define COIL_EXECUTE 4'h5
`define COIL_OVERRIDE 4'h6
`define COIL_TIME_ACK 4'h7
`define COIL_SCHED_ACK 4'h8
`define COIL_LATCH_RST 4'h9
`define COIL_ON 16'hff00
`define COIL_OFF 16'h0000

// Register control group
`define REG_EXECUTE 16'h0fff
`define REG_PASS_HI 16'h1000
`define REG_PASS_LO 16'h1001
`define REG_RESERVED 16'h1002
`define REG_SELECT 16'h1003
`define REG_FORCE 16'h1004
`define REG_STATE 16'h1005
`define EXEC_VALUE 16'h0001

// Select word bits
`define SEL_INTERLOCK 0
`define SEL_TRIP 1
`define SEL_CLOSE 2
`define SEL_CANCEL 3
`define SEL_WEAR_ACK 4
`define SEL_TIME_ACK 5
`define SEL_SCHED_ACK 6
`define SEL_LATCH_RST 7

// Limits and timing
`define RW_MAX_WORDS 9'd125
`define SELECT_DELAY_MS 500
`define CLK_MHZ 200
`define SELECT_DELAY_CYCLES (`SELECT_DELAY_MS * `CLK_MHZ * 1000)

`endif

// [hw/breaker_ctrl_pkg.sv]
// Types shared by the breaker control handler and its select timer.
// Assumes nothing beyond the constants header.
package breaker_ctrl_pkg;
    typedef enum logic [1:0] {
        SEL_IDLE = 2'b00,
        SEL_ARMED_TRIP = 2'b01,
        SEL_ARMED_CLOSE = 2'b10
    } sel_state_t;
endpackage

// [hw/select_link_if.sv]
// Carrier between the command decoder and the select-before-operate timer.
// Both ends run on ref_clk; every signal is a level sampled on that clock.
`timescale 1ns/1ps
interface select_link_if;
    logic arm_trip;
    logic arm_close;
    logic cancel;
    logic execute;
    logic armed_trip;
    logic armed_close;
    logic elapsed;
    logic fire_trip;
    logic fire_close;
    modport decoder (output arm_trip, arm_close, cancel, execute,
                     input armed_trip, armed_close, elapsed, fire_trip, fire_close);
    modport timer (input arm_trip, arm_close, cancel, execute,
                   output armed_trip, armed_close, elapsed, fire_trip, fire_close);
endinterface

// [hw/select_timer.sv]
// Select-before-operate timer: holds the armed trip or close and times it.
// Assumes one-cycle command pulses from the decoder on the same clock.
`timescale 1ns/1ps
`include "breaker_ctrl_defs.svh"
module select_timer
    import breaker_ctrl_pkg::*;
#(
    parameter int DELAY_CYCLES = `SELECT_DELAY_CYCLES
)(
    input wire logic ref_clk,
    input wire logic srst,
    select_link_if.timer link
);
    localparam int CW = $clog2(DELAY_CYCLES + 1);
    localparam logic [CW-1:0] DELAY = CW'(DELAY_CYCLES);

    if (DELAY_CYCLES < 1)
    begin : g_check
        $error("select delay must be at least one cycle");
    end

    sel_state_t state;
    logic [CW-1:0] count;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            state <= SEL_IDLE;
        else
            case (state)
                SEL_IDLE:
                begin
                    if (link.cancel)
                        state <= SEL_IDLE;
                    else if (link.arm_trip)
                        state <= SEL_ARMED_TRIP;
                    else if (link.arm_close)
                        state <= SEL_ARMED_CLOSE;
                end
                SEL_ARMED_TRIP, SEL_ARMED_CLOSE:
                begin
                    if (link.cancel)
                        state <= SEL_IDLE;
                    else if (link.execute && link.elapsed)
                        state <= SEL_IDLE;
                    else if (link.arm_trip)
                        state <= SEL_ARMED_TRIP;
                    else if (link.arm_close)
                        state <= SEL_ARMED_CLOSE;
                end
                default:
                    state <= SEL_IDLE;
            endcase
    end

    // A fresh select restarts the wait
    always_ff @(posedge ref_clk)
    begin
        if (srst || link.arm_trip || link.arm_close)
            count <= '0;
        else if (count < DELAY)
            count <= count + 1'b1;
    end

    // Early execute is answered normally but does nothing
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            link.fire_trip <= 1'b0;
            link.fire_close <= 1'b0;
        end
        else
        begin
            link.fire_trip <= (state == SEL_ARMED_TRIP) && link.execute && link.elapsed
                && !link.cancel;
            link.fire_close <= (state == SEL_ARMED_CLOSE) && link.execute && link.elapsed
                && !link.cancel;
        end
    end

    assign link.elapsed = (count >= DELAY);
    assign link.armed_trip = (state == SEL_ARMED_TRIP);
    assign link.armed_close = (state == SEL_ARMED_CLOSE);

    a_cancel_disarms: assert property (@(posedge ref_clk) disable iff (srst)
        link.cancel |=> state == SEL_IDLE)
        else $error("cancel left a selection armed");
    a_early_exec_noop: assert property (@(posedge ref_clk) disable iff (srst)
        link.execute && !link.elapsed |=> !link.fire_trip && !link.fire_close)
        else $error("execute acted before the select delay");
    a_unarmed_exec: assert property (@(posedge ref_clk) disable iff (srst)
        link.execute && state == SEL_IDLE |=> !link.fire_trip && !link.fire_close)
        else $error("execute acted with nothing armed");
    a_fire_disarms: assert property (@(posedge ref_clk) disable iff (srst)
        link.fire_trip || link.fire_close |-> state == SEL_IDLE && $past(link.elapsed))
        else $error("operation fired without clearing or before delay");
endmodule

// [hw/breaker_control_command_handler.sv]
// Breaker and interlock command handler behind a Modbus slave frame decoder.
// Assumes the decoder hands over one checked request item per req_valid cycle on ref_clk.
//
// Overview of operation
// - Execute earlier than 500 ms after select is answered but does not trip or close.
// - A one on the cancel coil disarms any pending trip or close selection.
// - Every control write gets a normal reply or an exception reply.
// - Zero written to the override coil turns interlock override off.
// - A one on the reset-latched coil clears latched outputs, single or multiple.
// - Register writes by functions 16, 23 and 06 carry password control.
// - Every coil control action is also reachable by register control.
// - Combined read/write is valid only for at most 125 words together.
// - Combined read/write does its writes and returns reads in one reply.
// - Register control checks the password and select-before-operate order.
// - Control block reads return present state of the protective functions.
// - Command coils return to zero by themselves after acting.
// - Execute register acts only when written with the value one.
// - A coil write setting more than one control bit is rejected.
`timescale 1ns/1ps
`include "breaker_ctrl_defs.svh"
module breaker_control_command_handler
    import breaker_ctrl_pkg::*;
#(
    parameter int SELECT_DELAY_CYCLES = `SELECT_DELAY_CYCLES,
    parameter logic [31:0] PASSWORD = 32'h0000_1234 // Arbitrary value
)(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire logic [7:0] req_func,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_data,
    input wire logic [4:0] req_qty,
    input wire logic [15:0] req_rd_addr,
    input wire logic [7:0] req_rd_qty,
    input wire logic [7:0] req_wr_qty,
    output logic resp_valid,
    output logic resp_exception,
    output logic [7:0] resp_exc_code,
    output logic [15:0] resp_data,
    output logic trip_cmd,
    output logic close_cmd,
    output logic override_on,
    output logic latched_reset,
    output logic wear_ack,
    output logic time_ack,
    output logic sched_ack,
    output logic [15:0] coil_image,
    output logic [7:0] function_state
);
    select_link_if link();

    select_timer #(.DELAY_CYCLES(SELECT_DELAY_CYCLES)) u_timer (
        .ref_clk(ref_clk),
        .srst(srst),
        .link(link)
    );

    logic [15:0] acts;
    logic [15:0] pass_hi;
    logic [15:0] pass_lo;
    logic [15:0] select_word;
    logic [15:0] force_word;
    logic next_exc;
    logic [7:0] next_code;
    logic [15:0] next_acts;
    logic [15:0] next_rdata;
    logic ovr_wr;
    logic ovr_val;
    logic pass_hi_wr;
    logic pass_lo_wr;
    logic sel_wr;
    logic frc_wr;
    logic pass_ok;
    logic [15:0] coil_off;
    logic [15:0] mask;
    logic [15:0] bits;
    logic [16:0] read_res;

    function automatic logic [4:0] ones(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++)
            n = n + {4'h0, v[i]};
        return n;
    endfunction

    // Control block reads, used by plain and combined reads
    function automatic logic [16:0] reg_read(input logic [15:0] a, input logic [15:0] sel,
                                             input logic [15:0] frc, input logic [7:0] st);
        case (a)
            `REG_EXECUTE, `REG_PASS_HI, `REG_PASS_LO, `REG_RESERVED:
                return {1'b1, 16'h0000};
            `REG_SELECT:
                return {1'b1, sel};
            `REG_FORCE:
                return {1'b1, frc};
            `REG_STATE:
                return {1'b1, 8'h00, st};
            default:
                return {1'b0, 16'h0000};
        endcase
    endfunction

    assign pass_ok = ({pass_hi, pass_lo} == PASSWORD);
    assign coil_off = req_addr - `COIL_BASE;
    assign mask = (req_qty >= `COIL_COUNT) ? 16'hffff : 16'((17'h1 << req_qty) - 17'h1);
    assign bits = req_data & mask;
    assign read_res = reg_read(req_rd_addr, select_word, force_word, function_state);

    always_comb
    begin
        next_exc = 1'b0;
        next_code = `EXC_NONE;
        next_acts = 16'h0000;
        next_rdata = 16'h0000;
        ovr_wr = 1'b0;
        ovr_val = 1'b0;
        pass_hi_wr = 1'b0;
        pass_lo_wr = 1'b0;
        sel_wr = 1'b0;
        frc_wr = 1'b0;
        case (req_func)
            `FC_WRITE_COIL:
            begin
                if (req_addr < `COIL_BASE || coil_off >= 16'(`COIL_COUNT))
                begin
                    next_exc = 1'b1;
                    next_code = `EXC_ADDR;
                end
                else if (req_data != `COIL_ON && req_data != `COIL_OFF)
                begin
                    next_exc = 1'b1;
                    next_code = `EXC_VALUE;
                end
                else if (coil_off[3:0] == `COIL_OVERRIDE)
                begin
                    ovr_wr = 1'b1;
                    ovr_val = (req_data == `COIL_ON);
                end
                else
                    next_acts[coil_off[3:0]] = (req_data == `COIL_ON);
            end
            `FC_WRITE_COILS:
            begin
                if (req_qty == 5'h00 || req_qty > `COIL_COUNT)
                begin
                    next_exc = 1'b1;
                    next_code = `EXC_VALUE;
                end
                else if (req_addr < `COIL_BASE || coil_off + 16'(req_qty) > 16'(`COIL_COUNT))
                begin
                    next_exc = 1'b1;
                    next_code = `EXC_ADDR;
                end
                else if (ones(bits) > 5'h01)
                begin
                    next_exc = 1'b1;
                    next_code = `EXC_VALUE;
                end
                else
                begin
                    next_acts = bits << coil_off[3:0];
                    if (coil_off[3:0] <= `COIL_OVERRIDE
                        && 16'(`COIL_OVERRIDE) < coil_off + 16'(req_qty))
                    begin
                        ovr_wr = 1'b1;
                        ovr_val = next_acts[`COIL_OVERRIDE];
                    end
                    next_acts[`COIL_OVERRIDE] = 1'b0;
                end
            end
            `FC_WRITE_REG, `FC_WRITE_REGS, `FC_RW_REGS:
            begin
                if (req_func == `FC_RW_REGS
                    && {1'b0, req_rd_qty} + {1'b0, req_wr_qty} > `RW_MAX_WORDS)
                begin
                    next_exc = 1'b1;
                    next_code = `EXC_VALUE;
                end
                else if (req_func == `FC_RW_REGS && !read_res[16])
                begin
                    next_exc = 1'b1;
                    next_code = `EXC_ADDR;
                end
                else
                begin
                    if (req_func == `FC_RW_REGS)
                        next_rdata = read_res[15:0];
                    case (req_addr)
                        `REG_EXECUTE:
                        begin
                            if (req_data == `EXEC_VALUE && !pass_ok)
                            begin
                                next_exc = 1'b1;
                                next_code = `EXC_VALUE;
                            end
                            else if (req_data == `EXEC_VALUE)
                            begin
                                next_acts[`COIL_EXECUTE] = 1'b1;
                                next_acts[`COIL_WEAR_ACK] = select_word[`SEL_WEAR_ACK];
                                next_acts[`COIL_TIME_ACK] = select_word[`SEL_TIME_ACK];
                                next_acts[`COIL_SCHED_ACK] = select_word[`SEL_SCHED_ACK];
                                next_acts[`COIL_LATCH_RST] = select_word[`SEL_LATCH_RST];
                                ovr_wr = select_word[`SEL_INTERLOCK];
                                ovr_val = force_word[`SEL_INTERLOCK];
                            end
                        end
                        `REG_PASS_HI:
                            pass_hi_wr = 1'b1;
                        `REG_PASS_LO:
                            pass_lo_wr = 1'b1;
                        `REG_RESERVED:
                            ;
                        `REG_SELECT:
                        begin
                            if (!pass_ok || (req_data[`SEL_TRIP] && req_data[`SEL_CLOSE]))
                            begin
                                next_exc = 1'b1;
                                next_code = `EXC_VALUE;
                            end
                            else
                            begin
                                sel_wr = 1'b1;
                                next_acts[`COIL_TRIP_SEL] = req_data[`SEL_TRIP];
                                next_acts[`COIL_CLOSE_SEL] = req_data[`SEL_CLOSE];
                                next_acts[`COIL_CANCEL] = req_data[`SEL_CANCEL];
                            end
                        end
                        `REG_FORCE:
                            frc_wr = 1'b1;
                        default:
                        begin
                            next_exc = 1'b1;
                            next_code = `EXC_ADDR;
                            next_rdata = 16'h0000;
                        end
                    endcase
                end
            end
            `FC_READ_REGS:
            begin
                if (read_res[16])
                    next_rdata = read_res[15:0];
                else
                begin
                    next_exc = 1'b1;
                    next_code = `EXC_ADDR;
                end
            end
            default:
            begin
                next_exc = 1'b1;
                next_code = `EXC_FUNC;
            end
        endcase
    end

    // Reply one cycle after the request
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            resp_valid <= 1'b0;
            resp_exception <= 1'b0;
            resp_exc_code <= `EXC_NONE;
            resp_data <= 16'h0000;
        end
        else
        begin
            resp_valid <= req_valid;
            resp_exception <= req_valid && next_exc;
            resp_exc_code <= req_valid ? next_code : `EXC_NONE;
            resp_data <= req_valid ? next_rdata : 16'h0000;
        end
    end

    // Actions last one cycle: command coils clear themselves
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            acts <= 16'h0000;
        else
            acts <= (req_valid && !next_exc) ? next_acts : 16'h0000;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            override_on <= 1'b0;
        else if (req_valid && !next_exc && ovr_wr)
            override_on <= ovr_val;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pass_hi <= 16'h0000;
            pass_lo <= 16'h0000;
            select_word <= 16'h0000;
            force_word <= 16'h0000;
        end
        else if (req_valid && !next_exc)
        begin
            if (pass_hi_wr)
                pass_hi <= req_data;
            if (pass_lo_wr)
                pass_lo <= req_data;
            if (sel_wr)
                select_word <= req_data;
            if (frc_wr)
                force_word <= req_data;
        end
    end

    assign link.arm_trip = acts[`COIL_TRIP_SEL];
    assign link.arm_close = acts[`COIL_CLOSE_SEL];
    assign link.cancel = acts[`COIL_CANCEL];
    assign link.execute = acts[`COIL_EXECUTE];

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            trip_cmd <= 1'b0;
            close_cmd <= 1'b0;
            latched_reset <= 1'b0;
            wear_ack <= 1'b0;
            time_ack <= 1'b0;
            sched_ack <= 1'b0;
            coil_image <= 16'h0000;
            function_state <= 8'h00;
        end
        else
        begin
            trip_cmd <= link.fire_trip;
            close_cmd <= link.fire_close;
            latched_reset <= acts[`COIL_LATCH_RST];
            wear_ack <= acts[`COIL_WEAR_ACK];
            time_ack <= acts[`COIL_TIME_ACK];
            sched_ack <= acts[`COIL_SCHED_ACK];
            coil_image <= acts | (16'(override_on) << `COIL_OVERRIDE);
            function_state <= {3'h0, pass_ok, link.elapsed, link.armed_close,
                               link.armed_trip, override_on};
        end
    end

    a_reply_follows: assert property (@(posedge ref_clk) disable iff (srst)
        req_valid |=> resp_valid ##1 !resp_valid || $past(req_valid))
        else $error("request not answered in one cycle");
    a_rw_limit: assert property (@(posedge ref_clk) disable iff (srst)
        req_valid && req_func == `FC_RW_REGS
        && {1'b0, req_rd_qty} + {1'b0, req_wr_qty} > `RW_MAX_WORDS
        |=> resp_exception && resp_exc_code == `EXC_VALUE)
        else $error("oversized read/write accepted");
    a_multi_reject: assert property (@(posedge ref_clk) disable iff (srst)
        req_valid && req_func == `FC_WRITE_COILS && ones(bits) > 5'h01
        |=> resp_exception ##1 coil_image == 16'($past(override_on)) << `COIL_OVERRIDE)
        else $error("multi-bit coil write was not rejected");
    a_coil_autoclear: assert property (@(posedge ref_clk) disable iff (srst)
        coil_image[`COIL_TRIP_SEL] && !acts[`COIL_TRIP_SEL] |=> !coil_image[`COIL_TRIP_SEL])
        else $error("command coil did not return to zero");
    a_exec_only_one: assert property (@(posedge ref_clk) disable iff (srst)
        req_valid && req_addr == `REG_EXECUTE && req_func == `FC_WRITE_REG
        && req_data != `EXEC_VALUE |=> !link.execute)
        else $error("execute register acted on a value other than one");
    a_override_off: assert property (@(posedge ref_clk) disable iff (srst)
        req_valid && req_func == `FC_WRITE_COIL && req_addr == `COIL_BASE + 16'h0006
        && req_data == `COIL_OFF |=> !override_on)
        else $error("override stayed on after zero write");
    a_latch_reset: assert property (@(posedge ref_clk) disable iff (srst)
        req_valid && req_func == `FC_WRITE_COIL && req_addr == `COIL_BASE + 16'h0009
        && req_data == `COIL_ON |=> ##1 latched_reset ##1 !latched_reset)
        else $error("latched reset pulse missing");
    a_password_gate: assert property (@(posedge ref_clk) disable iff (srst)
        req_valid && req_addr == `REG_SELECT && req_func == `FC_WRITE_REG && !pass_ok
        |=> resp_exception && !link.arm_trip && !link.arm_close)
        else $error("selection accepted without password");
endmodule

// [bench/host_model.sv]
// Master host model: hands the handler one decoded request item per call.
// Assumes the handler takes each item on a rising ref_clk edge.
`timescale 1ns/1ps
module host_model (
    input wire logic ref_clk,
    output logic req_valid,
    output logic [7:0] req_func,
    output logic [15:0] req_addr,
    output logic [15:0] req_data,
    output logic [4:0] req_qty,
    output logic [15:0] req_rd_addr,
    output logic [7:0] req_rd_qty,
    output logic [7:0] req_wr_qty
);
    initial
    begin
        {req_valid, req_func, req_addr, req_data, req_qty} = '0;
        {req_rd_addr, req_rd_qty, req_wr_qty} = '0;
    end
    task send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
        input logic [4:0] q = 5'h01, input logic [15:0] ra = 16'h1005,
        input logic [7:0] rq = 8'h01, input logic [7:0] wq = 8'h01);
        @(negedge ref_clk);
        {req_valid, req_func, req_addr, req_data} = {1'b1, f, a, d};
        {req_qty, req_rd_addr, req_rd_qty, req_wr_qty} = {q, ra, rq, wq};
        @(negedge ref_clk);
        // Scrambled between items so a stale field never looks valid
        {req_valid, req_func, req_addr, req_data} = {1'b0, ~f, ~a, ~d};
        {req_qty, req_rd_addr, req_rd_qty, req_wr_qty} = ~{q, ra, rq, wq};
    endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench for the breaker command handler.
// Assumes host_model drives requests; the select delay is shortened.
`timescale 1ns/1ps
module testbench;
    localparam int D = 20;
    logic ref_clk, srst, req_valid, resp_valid, resp_exception, trip_cmd, close_cmd;
    logic override_on, latched_reset, wear_ack, time_ack, sched_ack;
    logic [7:0] req_func, resp_exc_code, req_rd_qty, req_wr_qty, function_state;
    logic [15:0] req_addr, req_data, req_rd_addr, resp_data, coil_image;
    logic [4:0] req_qty;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    host_model host_model_i (.ref_clk, .req_valid, .req_func, .req_addr, .req_data,
        .req_qty, .req_rd_addr, .req_rd_qty, .req_wr_qty);
    breaker_control_command_handler #(.SELECT_DELAY_CYCLES(D))
    breaker_control_command_handler_i (.ref_clk, .srst, .req_valid, .req_func,
        .req_addr, .req_data, .req_qty, .req_rd_addr, .req_rd_qty, .req_wr_qty,
        .resp_valid, .resp_exception, .resp_exc_code, .resp_data, .trip_cmd,
        .close_cmd, .override_on, .latched_reset, .wear_ack, .time_ack,
        .sched_ack, .coil_image, .function_state);
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task final_report;
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Limit far above the few hundred cycles the scenarios need
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            final_report;
        end
    end
    task chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task rsp(input logic [7:0] e);
        chk(resp_valid, 1'b1);
        chk(resp_exc_code, e);
        chk(resp_exception, e != 8'h00);
    endtask
    // Operations seen over four cycles: trip counts 1, close counts 2
    task ops(input logic [15:0] e);
        logic [15:0] n;
        n = '0;
        repeat (4)
        begin
            @(negedge ref_clk);
            n = n + {close_cmd, trip_cmd};
        end
        chk(n, e);
    endtask
    task t_trip;
        host_model_i.send(8'h05, 16'h2002, 16'hff00);
        rsp(8'h00);
        host_model_i.send(8'h05, 16'h2005, 16'hff00);
        ops(0);
        idle(D + 2);
        host_model_i.send(8'h05, 16'h2005, 16'hff00);
        ops(1);
        host_model_i.send(8'h05, 16'h2005, 16'hff00);
        ops(0);
    endtask
    task t_cancel;
        host_model_i.send(8'h05, 16'h2003, 16'hff00);
        idle(D + 2);
        host_model_i.send(8'h05, 16'h2004, 16'hff00);
        rsp(8'h00);
        host_model_i.send(8'h05, 16'h2005, 16'hff00);
        ops(0);
        chk(coil_image, 16'h0000);
        host_model_i.send(8'h05, 16'h2003, 16'hff00);
        idle(D + 2);
        host_model_i.send(8'h05, 16'h2005, 16'hff00);
        ops(2);
    endtask
    task t_override;
        host_model_i.send(8'h05, 16'h2006, 16'hff00);
        chk(override_on, 1'b1);
        host_model_i.send(8'h0f, 16'h2001, 16'h0003, 5'h02);
        rsp(8'h03);
        chk(override_on, 1'b1);
        host_model_i.send(8'h05, 16'h2006, 16'h0000);
        chk(override_on, 1'b0);
    endtask
    task t_latch;
        host_model_i.send(8'h05, 16'h2009, 16'hff00);
        idle(1);
        chk(latched_reset, 1'b1);
        host_model_i.send(8'h0f, 16'h2009, 16'h0001, 5'h01);
        idle(1);
        chk(latched_reset, 1'b1);
        host_model_i.send(8'h05, 16'h2001, 16'hff00);
        idle(1);
        chk({wear_ack, time_ack, sched_ack}, 16'h0004);
        host_model_i.send(8'h05, 16'h2007, 16'hff00);
        idle(1);
        chk({wear_ack, time_ack, sched_ack}, 16'h0002);
        host_model_i.send(8'h05, 16'h2008, 16'hff00);
        idle(1);
        chk({wear_ack, time_ack, sched_ack}, 16'h0001);
    endtask
    task t_reg;
        host_model_i.send(8'h06, 16'h1000, 16'h0000);
        host_model_i.send(8'h06, 16'h1001, 16'h1234);
        host_model_i.send(8'h10, 16'h1003, 16'h0002);
        host_model_i.send(8'h03, 16'h0000, 16'h0000, 5'h01, 16'h1003);
        chk(resp_data, 16'h0002);
        idle(D + 2);
        host_model_i.send(8'h06, 16'h0fff, 16'h0002);
        ops(0);
        host_model_i.send(8'h17, 16'h1004, 16'h0000, 5'h01, 16'h1005, 8'd124, 8'd1);
        rsp(8'h00);
        chk(resp_data & 16'h0012, 16'h0012);
        host_model_i.send(8'h17, 16'h1004, 16'h0000, 5'h01, 16'h1005, 8'd100, 8'd26);
        rsp(8'h03);
        host_model_i.send(8'h17, 16'h0fff, 16'h0001);
        chk(resp_data & 16'h0002, 16'h0002);
        ops(1);
        host_model_i.send(8'h06, 16'h1001, 16'h0000);
        host_model_i.send(8'h06, 16'h0fff, 16'h0001);
        rsp(8'h03);
        host_model_i.send(8'h06, 16'h1003, 16'h0002);
        rsp(8'h03);
    endtask
    initial
    begin
        srst = 1'b1;
        idle(10);
        srst = 1'b0;
        t_trip;
        t_cancel;
        t_override;
        t_latch;
        t_reg;
        idle(4);
        final_report;
    end
endmodule
